// ---- logic/adcwt_top.sv ----
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module adcwt_top (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic EVENT_IN,
  input wire logic SLEEP_STANDBY,
  input wire logic SLEEP_POWERDOWN,
  input wire logic TOUCH_ENABLE,
  input wire logic SAR_DONE,
  input wire logic [9:0] SAR_DATA,
  output logic SAR_START,
  output logic [4:0] SAR_CHANNEL,
  output logic CLK_REQUEST,
  output logic IRQ_RESULT_READY,
  output logic IRQ_WINDOW_MATCH
);
  // Bus slave state
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_idx_q, wr_idx_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic rd_accept, wr_accept, res_read;
  logic [7:0] a_idx;

  // Software registers
  logic [7:0] main_q, main_d, accum_q, accum_d, refpre_q, refpre_d;
  logic [7:0] delay_q, delay_d, sampl_q, sampl_d, chan_q, chan_d;
  logic [7:0] evctl_q, evctl_d, inten_q, inten_d, dbg_q, dbg_d, scratch_q, scratch_d;
  logic [2:0] mode_q, mode_d;
  logic [15:0] lower_q, lower_d, upper_q, upper_d;

  // Conversion state
  adcwt_pkg::adcwt_state_t state_q, state_d;
  logic start_q, start_d, active_q, active_d, standby_q, standby_d, event_q, event_d;
  logic init_pend_q, init_pend_d, halted_q, halted_d, invalid_q, invalid_d;
  logic [8:0] presc_cnt_q, presc_cnt_d, dly_cnt_q, dly_cnt_d;
  logic [5:0] samp_cnt_q, samp_cnt_d;
  logic [15:0] acc_q, acc_d, res_q, res_d;
  logic [1:0] flags_q, flags_d;
  logic sar_start_q, sar_start_d, clk_req_q, clk_req_d;
  logic irq_rdy_q, irq_rdy_d, irq_win_q, irq_win_d;

  logic active, ev_rise, adc_tick, last_sample, result_write, win_hit_now, sample_done;
  logic sw_start, cmd_write, flag_clr_rdy, flag_clr_win;
  logic [8:0] presc_lim, dly_lim;
  logic [5:0] samp_lim;
  logic [2:0] acc_code, dly_code;
  logic [15:0] sample, acc_sum;

  function automatic logic window_hit(input logic [2:0] m, input logic [15:0] r,
                                      input logic [15:0] lo, input logic [15:0] hi);
    case (m)
      adcwt_pkg::WIN_BELOW: window_hit = r < lo;
      adcwt_pkg::WIN_ABOVE: window_hit = r > hi;
      adcwt_pkg::WIN_INSIDE: window_hit = (lo < r) && (r < hi);
      adcwt_pkg::WIN_OUTSIDE: window_hit = (r < lo) || (r > hi);
      default: window_hit = 1'b0;
    endcase
  endfunction

  // Bus slave: zero wait states, read data launched from the address phase
  always_comb begin
    a_idx = HADDR[adcwt_pkg::IDX_ADDR_MSB:adcwt_pkg::IDX_ADDR_LSB];
    if (HADDR[1:0] != 2'h0) begin
      a_idx = adcwt_pkg::IDX_UNMAPPED;
    end
    rd_accept = HSEL & HTRANS[adcwt_pkg::HTRANS_ACTIVE_BIT] & HREADY & ~HWRITE;
    wr_accept = HSEL & HTRANS[adcwt_pkg::HTRANS_ACTIVE_BIT] & HREADY & HWRITE;
    res_read = rd_accept && (a_idx == adcwt_pkg::IDX_RESULT);
    wr_pend_d = wr_accept;
    wr_idx_d = wr_accept ? a_idx : wr_idx_q;
    hrdata_d = hrdata_q;
    if (rd_accept) begin
      hrdata_d = 32'h0000_0000;
      case (a_idx)
        adcwt_pkg::IDX_MAIN_CONTROL: hrdata_d[7:0] = main_q;
        adcwt_pkg::IDX_ACCUM_CONTROL: hrdata_d[7:0] = accum_q;
        adcwt_pkg::IDX_REF_PRESCALE: hrdata_d[7:0] = refpre_q;
        adcwt_pkg::IDX_DELAY_CONTROL: hrdata_d[7:0] = delay_q;
        adcwt_pkg::IDX_WINDOW_MODE: hrdata_d[2:0] = mode_q;
        adcwt_pkg::IDX_SAMPLE_LENGTH: hrdata_d[7:0] = sampl_q;
        adcwt_pkg::IDX_CHANNEL_SELECT: hrdata_d[7:0] = chan_q;
        adcwt_pkg::IDX_CONV_COMMAND: hrdata_d[adcwt_pkg::START_CONVERSION_BIT] = start_q;
        adcwt_pkg::IDX_EVENT_CONTROL: hrdata_d[7:0] = evctl_q;
        adcwt_pkg::IDX_INT_ENABLE: hrdata_d[7:0] = inten_q;
        adcwt_pkg::IDX_INT_FLAGS: hrdata_d[1:0] = flags_q;
        adcwt_pkg::IDX_DEBUG_CONTROL: hrdata_d[7:0] = dbg_q;
        adcwt_pkg::IDX_BYTE_SCRATCH: hrdata_d[7:0] = scratch_q;
        adcwt_pkg::IDX_RESULT: hrdata_d[15:0] = res_q;
        adcwt_pkg::IDX_LOWER_THRESHOLD: hrdata_d[15:0] = lower_q;
        adcwt_pkg::IDX_UPPER_THRESHOLD: hrdata_d[15:0] = upper_q;
        adcwt_pkg::IDX_STATUS: begin
          hrdata_d[adcwt_pkg::STATUS_BUSY_BIT] = state_q != adcwt_pkg::ST_IDLE;
          hrdata_d[adcwt_pkg::STATUS_INVALID_BIT] = invalid_q;
          hrdata_d[adcwt_pkg::STATUS_TOUCH_BIT] = TOUCH_ENABLE;
        end
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= adcwt_pkg::IDX_UNMAPPED;
      hrdata_q <= 32'h0000_0000;
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      hrdata_q <= hrdata_d;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end
  assign HRDATA = hrdata_q;

  // Software registers, written in the data phase
  always_comb begin
    main_d = main_q;
    accum_d = accum_q;
    refpre_d = refpre_q;
    delay_d = delay_q;
    mode_d = mode_q;
    sampl_d = sampl_q;
    chan_d = chan_q;
    evctl_d = evctl_q;
    inten_d = inten_q;
    dbg_d = dbg_q;
    scratch_d = scratch_q;
    lower_d = lower_q;
    upper_d = upper_q;
    cmd_write = 1'b0;
    flag_clr_rdy = 1'b0;
    flag_clr_win = 1'b0;
    // Sampling delay steps after every sample when variation is on
    if (sample_done && delay_q[adcwt_pkg::ASDV_BIT]) begin
      delay_d[3:0] = delay_q[3:0] + 4'h1;
    end
    if (wr_pend_q) begin
      case (wr_idx_q)
        adcwt_pkg::IDX_MAIN_CONTROL: main_d = HWDATA[7:0] & adcwt_pkg::MASK_MAIN_CONTROL;
        adcwt_pkg::IDX_ACCUM_CONTROL: accum_d = HWDATA[7:0] & adcwt_pkg::MASK_ACCUM_CONTROL;
        adcwt_pkg::IDX_REF_PRESCALE: refpre_d = HWDATA[7:0] & adcwt_pkg::MASK_REF_PRESCALE;
        adcwt_pkg::IDX_DELAY_CONTROL: delay_d = HWDATA[7:0];
        adcwt_pkg::IDX_WINDOW_MODE: begin
          if (HWDATA[7:0] <= {5'h00, adcwt_pkg::WIN_OUTSIDE}) begin
            mode_d = HWDATA[2:0];
          end
        end
        adcwt_pkg::IDX_SAMPLE_LENGTH: sampl_d = HWDATA[7:0] & adcwt_pkg::MASK_SAMPLE_LENGTH;
        adcwt_pkg::IDX_CHANNEL_SELECT: chan_d = HWDATA[7:0] & adcwt_pkg::MASK_CHANNEL_SELECT;
        adcwt_pkg::IDX_CONV_COMMAND: cmd_write = HWDATA[adcwt_pkg::START_CONVERSION_BIT];
        adcwt_pkg::IDX_EVENT_CONTROL: evctl_d = HWDATA[7:0] & adcwt_pkg::MASK_SINGLE_BIT;
        adcwt_pkg::IDX_INT_ENABLE: inten_d = HWDATA[7:0] & adcwt_pkg::MASK_INT_BITS;
        adcwt_pkg::IDX_INT_FLAGS: begin
          flag_clr_rdy = HWDATA[adcwt_pkg::RESULT_READY_BIT];
          flag_clr_win = HWDATA[adcwt_pkg::WINDOW_MATCH_BIT];
        end
        adcwt_pkg::IDX_DEBUG_CONTROL: dbg_d = HWDATA[7:0] & adcwt_pkg::MASK_SINGLE_BIT;
        adcwt_pkg::IDX_BYTE_SCRATCH: scratch_d = HWDATA[7:0];
        adcwt_pkg::IDX_LOWER_THRESHOLD: lower_d = HWDATA[15:0];
        adcwt_pkg::IDX_UPPER_THRESHOLD: upper_d = HWDATA[15:0];
        default: cmd_write = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      main_q <= adcwt_pkg::BYTE_RESET;
      accum_q <= adcwt_pkg::BYTE_RESET;
      refpre_q <= adcwt_pkg::BYTE_RESET;
      delay_q <= adcwt_pkg::BYTE_RESET;
      mode_q <= adcwt_pkg::WIN_NONE;
      sampl_q <= adcwt_pkg::BYTE_RESET;
      chan_q <= adcwt_pkg::BYTE_RESET;
      evctl_q <= adcwt_pkg::BYTE_RESET;
      inten_q <= adcwt_pkg::BYTE_RESET;
      dbg_q <= adcwt_pkg::BYTE_RESET;
      scratch_q <= adcwt_pkg::BYTE_RESET;
      lower_q <= adcwt_pkg::WORD_RESET;
      upper_q <= adcwt_pkg::WORD_RESET;
    end else begin
      main_q <= main_d;
      accum_q <= accum_d;
      refpre_q <= refpre_d;
      delay_q <= delay_d;
      mode_q <= mode_d;
      sampl_q <= sampl_d;
      chan_q <= chan_d;
      evctl_q <= evctl_d;
      inten_q <= inten_d;
      dbg_q <= dbg_d;
      scratch_q <= scratch_d;
      lower_q <= lower_d;
      upper_q <= upper_d;
    end
  end

  // Conversion sequencer
  always_comb begin
    active = main_q[adcwt_pkg::ENABLE_BIT] & ~TOUCH_ENABLE
             & ~(SLEEP_STANDBY & ~main_q[adcwt_pkg::RUN_IN_STANDBY_BIT]);
    ev_rise = EVENT_IN & ~event_q;
    // Software starts are refused in standby: only events may start there
    sw_start = cmd_write & ~SLEEP_STANDBY;
    presc_lim = 9'((9'h002 << refpre_q[2:0]) - 9'h001);
    adc_tick = presc_cnt_q == presc_lim;
    acc_code = (accum_q[2:0] > adcwt_pkg::ACC_MAX_CODE) ? 3'h0 : accum_q[2:0];
    samp_lim = 6'((7'h01 << acc_code) - 7'h01);
    dly_code = delay_q[7:5];
    dly_lim = 9'((adcwt_pkg::DLY_BASE_TICKS << (dly_code - 3'h1)) - 9'h001);
    last_sample = samp_cnt_q == samp_lim;
    sample = main_q[adcwt_pkg::RESOLUTION_SELECT_BIT] ? {8'h00, SAR_DATA[9:2]}
                                                      : {6'h00, SAR_DATA};
    acc_sum = acc_q + sample;
    state_d = state_q;
    start_d = start_q;
    presc_cnt_d = presc_cnt_q;
    dly_cnt_d = dly_cnt_q;
    samp_cnt_d = samp_cnt_q;
    acc_d = acc_q;
    res_d = res_q;
    halted_d = halted_q;
    invalid_d = invalid_q;
    sar_start_d = 1'b0;
    sample_done = 1'b0;
    result_write = 1'b0;
    active_d = active;
    standby_d = SLEEP_STANDBY;
    event_d = EVENT_IN;
    init_pend_d = init_pend_q | (active & ~active_q) | (active & SLEEP_STANDBY & ~standby_q);
    if (active && (sw_start || (ev_rise && evctl_q[adcwt_pkg::EVENT_START_ENABLE_BIT]))) begin
      start_d = 1'b1;
    end
    if (!active) begin
      state_d = adcwt_pkg::ST_IDLE;
      start_d = 1'b0;
      presc_cnt_d = 9'h000;
    end else if (SLEEP_POWERDOWN) begin
      // Sequencer state and counters freeze; a conversion in progress is marked halted
      halted_d = halted_q | (state_q != adcwt_pkg::ST_IDLE);
    end else begin
      if (state_q != adcwt_pkg::ST_IDLE) begin
        presc_cnt_d = adc_tick ? 9'h000 : 9'(presc_cnt_q + 9'h001);
      end
      case (state_q)
        adcwt_pkg::ST_IDLE: begin
          presc_cnt_d = 9'h000;
          if (start_q) begin
            acc_d = adcwt_pkg::WORD_RESET;
            samp_cnt_d = 6'h00;
            dly_cnt_d = 9'h000;
            halted_d = 1'b0;
            init_pend_d = 1'b0;
            if (init_pend_q && dly_code != 3'h0 && dly_code <= adcwt_pkg::DLY_MAX_CODE) begin
              state_d = adcwt_pkg::ST_INIT;
            end else begin
              state_d = adcwt_pkg::ST_ISSUE;
            end
          end
        end
        adcwt_pkg::ST_INIT: begin
          if (adc_tick) begin
            dly_cnt_d = 9'(dly_cnt_q + 9'h001);
            if (dly_cnt_q == dly_lim) begin
              state_d = adcwt_pkg::ST_ISSUE;
            end
          end
        end
        adcwt_pkg::ST_ISSUE: begin
          if (adc_tick) begin
            sar_start_d = 1'b1;
            state_d = adcwt_pkg::ST_WAIT;
          end
        end
        adcwt_pkg::ST_WAIT: begin
          if (SAR_DONE) begin
            sample_done = 1'b1;
            acc_d = acc_sum;
            if (last_sample) begin
              result_write = 1'b1;
              res_d = acc_sum;
              invalid_d = halted_q;
              start_d = 1'b0;
              state_d = adcwt_pkg::ST_IDLE;
            end else begin
              samp_cnt_d = 6'(samp_cnt_q + 6'h01);
              state_d = adcwt_pkg::ST_ISSUE;
            end
          end
        end
        default: state_d = adcwt_pkg::ST_IDLE;
      endcase
    end
    // Window result is judged on the value being written, never on stale data
    win_hit_now = result_write && window_hit(mode_q, acc_sum, lower_q, upper_q);
    // A new event outranks a clear landing in the same cycle
    flags_d[adcwt_pkg::RESULT_READY_BIT] = result_write
      | (flags_q[adcwt_pkg::RESULT_READY_BIT] & ~flag_clr_rdy & ~res_read);
    flags_d[adcwt_pkg::WINDOW_MATCH_BIT] = win_hit_now
      | (flags_q[adcwt_pkg::WINDOW_MATCH_BIT] & ~flag_clr_win);
    irq_rdy_d = flags_d[adcwt_pkg::RESULT_READY_BIT] & inten_d[adcwt_pkg::RESULT_READY_BIT];
    irq_win_d = flags_d[adcwt_pkg::WINDOW_MATCH_BIT] & inten_d[adcwt_pkg::WINDOW_MATCH_BIT];
    clk_req_d = SLEEP_STANDBY & ((state_d != adcwt_pkg::ST_IDLE) | start_d);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_q <= adcwt_pkg::ST_IDLE;
      start_q <= 1'b0;
      active_q <= 1'b0;
      standby_q <= 1'b0;
      event_q <= 1'b0;
      init_pend_q <= 1'b0;
      halted_q <= 1'b0;
      invalid_q <= 1'b0;
      presc_cnt_q <= 9'h000;
      dly_cnt_q <= 9'h000;
      samp_cnt_q <= 6'h00;
      acc_q <= adcwt_pkg::WORD_RESET;
      res_q <= adcwt_pkg::WORD_RESET;
      flags_q <= 2'h0;
      sar_start_q <= 1'b0;
      clk_req_q <= 1'b0;
      irq_rdy_q <= 1'b0;
      irq_win_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      active_q <= active_d;
      standby_q <= standby_d;
      event_q <= event_d;
      init_pend_q <= init_pend_d;
      halted_q <= halted_d;
      invalid_q <= invalid_d;
      presc_cnt_q <= presc_cnt_d;
      dly_cnt_q <= dly_cnt_d;
      samp_cnt_q <= samp_cnt_d;
      acc_q <= acc_d;
      res_q <= res_d;
      flags_q <= flags_d;
      sar_start_q <= sar_start_d;
      clk_req_q <= clk_req_d;
      irq_rdy_q <= irq_rdy_d;
      irq_win_q <= irq_win_d;
    end
  end

  assign SAR_START = sar_start_q;
  assign SAR_CHANNEL = chan_q[4:0];
  assign CLK_REQUEST = clk_req_q;
  assign IRQ_RESULT_READY = irq_rdy_q;
  assign IRQ_WINDOW_MATCH = irq_win_q;

  default clocking adcwt_cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  AST_MODE_NONE_QUIET: assert property (
    result_write && mode_q == adcwt_pkg::WIN_NONE && !flags_q[adcwt_pkg::WINDOW_MATCH_BIT]
    |=> !flags_q[adcwt_pkg::WINDOW_MATCH_BIT])
    else $error("Window flag set with comparison off");
  AST_INSIDE_HIT: assert property (
    result_write && mode_q == adcwt_pkg::WIN_INSIDE && lower_q < acc_sum && acc_sum < upper_q
    |=> flags_q[adcwt_pkg::WINDOW_MATCH_BIT] && res_q > lower_q && res_q < upper_q)
    else $error("Inside result did not raise window flag");
  AST_OUTSIDE_HIT: assert property (
    result_write && mode_q == adcwt_pkg::WIN_OUTSIDE && (acc_sum < lower_q || acc_sum > upper_q)
    |=> flags_q[adcwt_pkg::WINDOW_MATCH_BIT])
    else $error("Outside result did not raise window flag");
  AST_WINDOW_WITH_READY: assert property (
    $rose(flags_q[adcwt_pkg::WINDOW_MATCH_BIT]) |-> flags_q[adcwt_pkg::RESULT_READY_BIT]
    && $past(result_write))
    else $error("Window flag rose without a result write");
  AST_IRQ_PAIRING: assert property (
    IRQ_WINDOW_MATCH |-> flags_q[adcwt_pkg::WINDOW_MATCH_BIT]
    && inten_q[adcwt_pkg::WINDOW_MATCH_BIT])
    else $error("Window request without flag and enable");
  AST_EVENT_START: assert property (
    ev_rise && active && evctl_q[adcwt_pkg::EVENT_START_ENABLE_BIT] && !result_write
    |=> start_q)
    else $error("Event edge did not set start bit");
  AST_START_CLEARS: assert property (
    result_write |=> !start_q && flags_q[adcwt_pkg::RESULT_READY_BIT] ##1 !SAR_START)
    else $error("Completion did not clear start bit");
  AST_STANDBY_OFF: assert property (
    SLEEP_STANDBY && !main_q[adcwt_pkg::RUN_IN_STANDBY_BIT] |=> state_q == adcwt_pkg::ST_IDLE)
    else $error("Converter ran in standby without run bit");
  AST_TOUCH_OWNS: assert property (
    TOUCH_ENABLE [*2] |=> !SAR_START)
    else $error("Conversion issued while touch controller owns converter");
  AST_POWERDOWN_HOLD: assert property (
    SLEEP_POWERDOWN && active |=> $stable(state_q) && $stable(acc_q))
    else $error("Conversion advanced in power-down");
  AST_EIGHT_BIT: assert property (
    result_write && main_q[adcwt_pkg::RESOLUTION_SELECT_BIT] && acc_code == 3'h0
    |=> res_q[15:8] == 8'h00)
    else $error("Eight-bit result exceeds eight bits");
endmodule

// ---- logic/adcwt_pkg.sv ----
package adcwt_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_MAIN_CONTROL = 8'h00;
  localparam logic [7:0] IDX_ACCUM_CONTROL = 8'h01;
  localparam logic [7:0] IDX_REF_PRESCALE = 8'h02;
  localparam logic [7:0] IDX_DELAY_CONTROL = 8'h03;
  localparam logic [7:0] IDX_WINDOW_MODE = 8'h04;
  localparam logic [7:0] IDX_SAMPLE_LENGTH = 8'h05;
  localparam logic [7:0] IDX_CHANNEL_SELECT = 8'h06;
  localparam logic [7:0] IDX_CONV_COMMAND = 8'h08;
  localparam logic [7:0] IDX_EVENT_CONTROL = 8'h09;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h0a;
  localparam logic [7:0] IDX_INT_FLAGS = 8'h0b;
  localparam logic [7:0] IDX_DEBUG_CONTROL = 8'h0c;
  localparam logic [7:0] IDX_BYTE_SCRATCH = 8'h0d;
  localparam logic [7:0] IDX_RESULT = 8'h10;
  localparam logic [7:0] IDX_LOWER_THRESHOLD = 8'h12;
  localparam logic [7:0] IDX_UPPER_THRESHOLD = 8'h14;
  localparam logic [7:0] IDX_STATUS = 8'h16;
  localparam logic [7:0] IDX_UNMAPPED = 8'hff;
  localparam int IDX_ADDR_LSB = 2;
  localparam int IDX_ADDR_MSB = 9;

  // Writable bits of each masked byte register
  localparam logic [7:0] MASK_MAIN_CONTROL = 8'h85;
  localparam logic [7:0] MASK_ACCUM_CONTROL = 8'h07;
  localparam logic [7:0] MASK_REF_PRESCALE = 8'h77;
  localparam logic [7:0] MASK_SAMPLE_LENGTH = 8'h1f;
  localparam logic [7:0] MASK_CHANNEL_SELECT = 8'h1f;
  localparam logic [7:0] MASK_SINGLE_BIT = 8'h01;
  localparam logic [7:0] MASK_INT_BITS = 8'h03;

  // Field positions
  localparam int RUN_IN_STANDBY_BIT = 7;
  localparam int RESOLUTION_SELECT_BIT = 2;
  localparam int ENABLE_BIT = 0;
  localparam int START_CONVERSION_BIT = 0;
  localparam int EVENT_START_ENABLE_BIT = 0;
  localparam int RESULT_READY_BIT = 0;
  localparam int WINDOW_MATCH_BIT = 1;
  localparam int ASDV_BIT = 4;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_INVALID_BIT = 1;
  localparam int STATUS_TOUCH_BIT = 2;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Window modes
  localparam logic [2:0] WIN_NONE = 3'h0;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // Accumulation and delay codes
  localparam logic [2:0] ACC_MAX_CODE = 3'h6;
  localparam logic [2:0] DLY_MAX_CODE = 3'h5;
  localparam logic [8:0] DLY_BASE_TICKS = 9'h010;

  typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_ISSUE, ST_WAIT} adcwt_state_t;
endpackage

// ---- verif/adcwt_sar_model.sv ----
`timescale 1ns/1ps
module adcwt_sar_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [9:0] value,
  output logic done,
  output logic [9:0] data
);
  initial done = 1'b0;
  initial data = 10'h3ff;
  // Slow answer; data is scrambled outside the done pulse so a late sample is caught
  always @(posedge clk) begin
    if (start === 1'b1) begin
      repeat (3) @(posedge clk);
      done <= 1'b1;
      data <= value;
      @(posedge clk);
      done <= 1'b0;
      data <= ~value;
    end
  end
endmodule

// ---- verif/tb_adc_window_trigger_control.sv ----
`timescale 1ns/1ps
module tb_adc_window_trigger_control;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0;
  logic HWRITE = 1'b0;
  logic EVENT_IN = 1'b0;
  logic SLEEP_STANDBY = 1'b0;
  logic SLEEP_POWERDOWN = 1'b0;
  logic TOUCH_ENABLE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = '0;
  logic [31:0] HWDATA = '0;
  logic [9:0] smp = '0;
  logic HREADYOUT, HRESP, SAR_START, SAR_DONE, CLK_REQUEST, seen;
  logic IRQ_RESULT_READY, IRQ_WINDOW_MATCH;
  logic [31:0] HRDATA;
  logic [9:0] SAR_DATA;
  logic [4:0] SAR_CHANNEL;
  logic [2:0] m;
  logic [15:0] lo, hi;
  logic [9:0] s;
  logic w;
  int fail_count = 0;
  int checks = 0;
  // Mode, lower, upper, sample, expected window flag
  logic [45:0] rows [9] = '{
    {3'h0, 16'h000a, 16'h0014, 10'h00f, 1'b0},
    {3'h1, 16'h0064, 16'h0000, 10'h063, 1'b1},
    {3'h1, 16'h0064, 16'h0000, 10'h064, 1'b0},
    {3'h2, 16'h0000, 16'h00c8, 10'h0c9, 1'b1},
    {3'h2, 16'h0000, 16'h00c8, 10'h0c8, 1'b0},
    {3'h3, 16'h0064, 16'h00c8, 10'h096, 1'b1},
    {3'h3, 16'h0064, 16'h00c8, 10'h064, 1'b0},
    {3'h4, 16'h0064, 16'h00c8, 10'h063, 1'b1},
    {3'h4, 16'h0064, 16'h00c8, 10'h096, 1'b0}};
  always #50 CORE_CLK = ~CORE_CLK;
  adcwt_top dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .EVENT_IN(EVENT_IN),
    .SLEEP_STANDBY(SLEEP_STANDBY), .SLEEP_POWERDOWN(SLEEP_POWERDOWN),
    .TOUCH_ENABLE(TOUCH_ENABLE),
    .SAR_DONE(SAR_DONE), .SAR_DATA(SAR_DATA), .SAR_START(SAR_START),
    .SAR_CHANNEL(SAR_CHANNEL), .CLK_REQUEST(CLK_REQUEST),
    .IRQ_RESULT_READY(IRQ_RESULT_READY), .IRQ_WINDOW_MATCH(IRQ_WINDOW_MATCH));
  adcwt_sar_model sar (.clk(CORE_CLK), .start(SAR_START), .value(smp), .done(SAR_DONE),
    .data(SAR_DATA));
  task final_report;
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task hwait;
    int n;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 100);
    if (n >= 100) begin
      fail_count++;
      final_report;
    end
  endtask
  // Entered just after a rising edge; returns at the edge that takes the data phase
  task bus(input logic wr, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {22'h0, i, 2'h0};
    hwait;
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    hwait;
    rd = HRDATA;
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, i, d, x);
  endtask
  // Idle cycle first: a read overlapping a write to the same place sees the old value
  task rchk(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] d;
    @(posedge CORE_CLK);
    bus(1'b0, i, '0, d);
    cmp(d, e);
  endtask
  task wait_ready;
    int n;
    n = 0;
    while (IRQ_RESULT_READY !== 1'b1 && n < 500) begin
      @(posedge CORE_CLK);
      seen = seen | CLK_REQUEST;
      n++;
    end
    if (n >= 500) begin
      fail_count++;
      final_report;
    end
  endtask
  initial begin
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(posedge CORE_CLK);
    wr(adcwt_pkg::IDX_MAIN_CONTROL, 32'h0000_0001);
    wr(adcwt_pkg::IDX_INT_ENABLE, 32'h0000_0003);
    for (int i = 0; i < 9; i++) begin
      {m, lo, hi, s, w} = rows[i];
      wr(adcwt_pkg::IDX_LOWER_THRESHOLD, {16'h0000, lo});
      wr(adcwt_pkg::IDX_UPPER_THRESHOLD, {16'h0000, hi});
      wr(adcwt_pkg::IDX_WINDOW_MODE, {29'h0, m});
      smp <= s;
      wr(adcwt_pkg::IDX_CONV_COMMAND, 32'h0000_0001);
      wait_ready;
      cmp({31'h0, IRQ_WINDOW_MATCH}, {31'h0, w});
      rchk(adcwt_pkg::IDX_INT_FLAGS, {30'h0, w, 1'b1});
      rchk(adcwt_pkg::IDX_RESULT, {22'h0, s});
      wr(adcwt_pkg::IDX_INT_FLAGS, 32'h0000_0003);
    end
    wr(adcwt_pkg::IDX_WINDOW_MODE, 32'h0000_0003);
    wr(adcwt_pkg::IDX_WINDOW_MODE, 32'h0000_0005);
    rchk(adcwt_pkg::IDX_WINDOW_MODE, 32'h0000_0003);
    wr(adcwt_pkg::IDX_MAIN_CONTROL, 32'h0000_00ff);
    rchk(adcwt_pkg::IDX_MAIN_CONTROL, 32'h0000_0085);
    wr(adcwt_pkg::IDX_MAIN_CONTROL, 32'h0000_0005);
    wr(adcwt_pkg::IDX_INT_ENABLE, 32'h0000_0001);
    wr(adcwt_pkg::IDX_ACCUM_CONTROL, 32'h0000_0001);
    wr(adcwt_pkg::IDX_UPPER_THRESHOLD, 32'h0000_0100);
    wr(adcwt_pkg::IDX_WINDOW_MODE, 32'h0000_0002);
    smp <= 10'h3ff;
    wr(adcwt_pkg::IDX_CONV_COMMAND, 32'h0000_0001);
    wait_ready;
    cmp({31'h0, IRQ_WINDOW_MATCH}, '0);
    rchk(adcwt_pkg::IDX_INT_FLAGS, 32'h0000_0003);
    rchk(adcwt_pkg::IDX_RESULT, 32'h0000_01fe);
    wr(adcwt_pkg::IDX_INT_FLAGS, 32'h0000_0003);
    wr(adcwt_pkg::IDX_ACCUM_CONTROL, '0);
    wr(adcwt_pkg::IDX_MAIN_CONTROL, 32'h0000_0081);
    wr(adcwt_pkg::IDX_EVENT_CONTROL, 32'h0000_0001);
    // Settling delay before the first conversion in standby
    wr(adcwt_pkg::IDX_DELAY_CONTROL, 32'h0000_0020);
    smp <= 10'h123;
    SLEEP_STANDBY <= 1'b1;
    @(posedge CORE_CLK);
    EVENT_IN <= 1'b1;
    seen = 1'b0;
    wait_ready;
    cmp({31'h0, seen}, 32'h0000_0001);
    rchk(adcwt_pkg::IDX_CONV_COMMAND, '0);
    rchk(adcwt_pkg::IDX_RESULT, 32'h0000_0123);
    cmp({31'h0, CLK_REQUEST}, '0);
    EVENT_IN <= 1'b0;
    SLEEP_STANDBY <= 1'b0;
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(posedge CORE_CLK);
    rchk(adcwt_pkg::IDX_MAIN_CONTROL, '0);
    rchk(adcwt_pkg::IDX_UNMAPPED, '0);
    cmp({31'h0, HRESP}, '0);
    wr(adcwt_pkg::IDX_MAIN_CONTROL, 32'h0000_0001);
    wr(adcwt_pkg::IDX_INT_ENABLE, 32'h0000_0001);
    TOUCH_ENABLE <= 1'b1;
    wr(adcwt_pkg::IDX_CONV_COMMAND, 32'h0000_0001);
    rchk(adcwt_pkg::IDX_CONV_COMMAND, '0);
    rchk(adcwt_pkg::IDX_STATUS, 32'h0000_0004);
    TOUCH_ENABLE <= 1'b0;
    wr(adcwt_pkg::IDX_CONV_COMMAND, 32'h0000_0001);
    // Sleep lands while the converter is waiting for its sample
    repeat (3) @(posedge CORE_CLK);
    SLEEP_POWERDOWN <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    SLEEP_POWERDOWN <= 1'b0;
    wait_ready;
    rchk(adcwt_pkg::IDX_STATUS, 32'h0000_0002);
    final_report;
  end
endmodule
